// *** design/i2c_slave_defs.vh ***
// i2c_slave_defs.vh: shared constants of the two-wire slave and its fifo
// assumes plain verilog-2005 include by bare name
`ifndef I2C_SLAVE_DEFS_VH
`define I2C_SLAVE_DEFS_VH

// target addresses, seven bits; memory block prefix four bits
`define RTC_ADDR        7'h68
`define MEM_BLOCK_HI    4'hA
`define MEM_LARGE_ADDR  7'h50
// register space sizes
`define RTC_SPACE_LAST  13'h0012
`define MEM_SMALL_LAST  13'h07FF
`define MEM_LARGE_LAST  13'h1FFF
`define PTR_ZERO        13'h0000
// direction bit values
`define DIR_READ        1'b1
// fifo
`define FIFO_DEPTH      32
`define FIFO_WIDTH      23

`endif

// *** design/stream_fifo.v ***
// stream_fifo.v: synchronous fifo, valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module stream_fifo #(
    parameter WIDTH = 23,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // clock and reset
    input  wire             clk_sys_in,
    input  wire             rst_in,
    // fill side
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    // drain side
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage words
    reg [AW:0]      wr_q;              // write pointer, extra wrap bit
    reg [AW:0]      rd_q;              // read pointer, extra wrap bit
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    assign full          = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    assign empty         = (wr_q == rd_q);
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = mem_q[rd_q[AW-1:0]];
    assign push          = in_valid_in && !full;
    assign pop           = out_ready_in && !empty;

    // pointers advance only on a real handshake
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    // storage has no reset, contents are don't-care while empty
    always @(posedge clk_sys_in) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_in;
        end
    end
endmodule // stream_fifo

// *** design/i2c_slave_access.v ***
// i2c_slave_access.v: two-wire slave front end for clock registers and byte memory
// assumes scl and sda arrive asynchronously and are far slower than clk_sys_in;
// the storage behind it sits outside and answers reads within one system clock
`timescale 1ns/1ps
`include "i2c_slave_defs.vh"

module i2c_slave_access #(
    parameter LARGE_MEM = 0,          // 1 selects the 8k memory variant
    parameter FIFO_DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input  wire        clk_sys_in,
    input  wire        rst_in,
    // two-wire pins
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe_out,
    // write stream to storage: {target, address, data}
    output wire        wr_valid_out,
    input  wire        wr_ready_in,
    output wire [1:0]  wr_target_out,
    output wire [12:0] wr_addr_out,
    output wire [7:0]  wr_data_out,
    // read request to storage and its answer
    output reg         rd_req_out,
    output reg  [1:0]  rd_target_out,
    output reg  [12:0] rd_addr_out,
    input  wire [7:0]  rd_data_in,
    // status
    output reg         busy_out
);
    // states
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_RX   = 3'd2;
    localparam ST_RACK = 3'd3;
    localparam ST_TX   = 3'd4;
    localparam ST_TACK = 3'd5;
    // targets
    localparam TG_RTC  = 2'd0;
    localparam TG_MEM  = 2'd1;

    reg [2:0]  scl_s_q, sda_s_q;    // two-flop sync, [0] first flop, [2] history
    reg [2:0]  st_q;
    reg [3:0]  bit_q;               // bit count inside a byte
    reg [7:0]  sh_q;                // receive/transmit shift
    reg [1:0]  tg_q;                // target addressed
    reg [1:0]  phase_q;             // 0 first ptr byte, 1 second ptr byte, 2 data
    reg [12:0] ptr_rtc_q;           // pointer of clock target
    reg [12:0] ptr_mem_q;           // pointer of memory target
    reg        rw_q;
    reg        ack_pend_q;          // read fetched, load byte next cycle
    reg        nack_q;              // master said stop sending
    wire       scl_rise, scl_fall, start_c, stop_c;
    wire [12:0] cur_ptr, next_ptr, space_last;
    wire       fifo_ready;
    reg        push_q;
    reg [22:0] push_data_q;         // {target, address, data}

    // edges read only the second flop and its history
    assign scl_rise = scl_s_q[1] && !scl_s_q[2];
    assign scl_fall = !scl_s_q[1] && scl_s_q[2];
    assign start_c  = scl_s_q[1] && scl_s_q[2] && !sda_s_q[1] && sda_s_q[2];
    assign stop_c   = scl_s_q[1] && scl_s_q[2] && sda_s_q[1] && !sda_s_q[2];
    assign cur_ptr  = (tg_q == TG_RTC) ? ptr_rtc_q : ptr_mem_q;
    assign space_last = (tg_q == TG_RTC) ? `RTC_SPACE_LAST :
                        (LARGE_MEM ? `MEM_LARGE_LAST : `MEM_SMALL_LAST);
    assign next_ptr = (cur_ptr == space_last) ? `PTR_ZERO : cur_ptr + 13'd1;

    // synchronisers for the two pins
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            scl_s_q <= 3'b111;
            sda_s_q <= 3'b111;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_in};
            sda_s_q <= {sda_s_q[1:0], sda_in};
        end
    end

    // write stream buffer; a full buffer stretches nothing, so the
    // bus master must stay below the drain rate of the storage
    stream_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (5)
    ) u_wr_fifo (
        .clk_sys_in    (clk_sys_in),
        .rst_in        (rst_in),
        .in_valid_in   (push_q),
        .in_ready_out  (fifo_ready),
        .in_data_in    (push_data_q),
        .out_valid_out (wr_valid_out),
        .out_ready_in  (wr_ready_in),
        .out_data_out  ({wr_target_out, wr_addr_out, wr_data_out})
    );

    // main protocol machine
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_q <= ST_IDLE;
            bit_q <= 4'd0;
            sh_q <= 8'h00;
            tg_q <= TG_RTC;
            phase_q <= 2'd0;
            ptr_rtc_q <= `PTR_ZERO;
            ptr_mem_q <= `PTR_ZERO;
            rw_q <= 1'b0;
            ack_pend_q <= 1'b0;
            nack_q <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= 23'h000000;
            rd_req_out <= 1'b0;
            rd_target_out <= TG_RTC;
            rd_addr_out <= `PTR_ZERO;
            busy_out <= 1'b0;
        end else begin
            push_q <= 1'b0;
            rd_req_out <= 1'b0;
            if (start_c) begin
                // new transfer, also repeated start
                st_q <= ST_ADDR;
                bit_q <= 4'd0;
                sda_oe_out <= 1'b0;
                busy_out <= 1'b1;
            end else if (stop_c) begin
                st_q <= ST_IDLE;
                sda_oe_out <= 1'b0;
                busy_out <= 1'b0;
            end else begin
                case (st_q)
                    ST_ADDR, ST_RX: begin
                        // sample data on rising scl
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda_s_q[1]};
                            bit_q <= bit_q + 4'd1;
                        end else if (scl_fall && bit_q == 4'd8) begin
                            bit_q <= 4'd0;
                            if (st_q == ST_ADDR) begin
                                rw_q <= (sh_q[0] == `DIR_READ);
                                if (sh_q[7:1] == `RTC_ADDR) begin
                                    tg_q <= TG_RTC;
                                    st_q <= ST_RACK;
                                    sda_oe_out <= 1'b1;
                                end else if (LARGE_MEM ? (sh_q[7:1] == `MEM_LARGE_ADDR)
                                                       : (sh_q[7:4] == `MEM_BLOCK_HI)) begin
                                    tg_q <= TG_MEM;
                                    if (!LARGE_MEM) begin
                                        // block bits are the upper address bits, both directions
                                        ptr_mem_q <= {2'b00, sh_q[3:1], ptr_mem_q[7:0]};
                                    end
                                    st_q <= ST_RACK;
                                    sda_oe_out <= 1'b1;
                                end else begin
                                    st_q <= ST_IDLE; // not for us, wait for start
                                end
                                phase_q <= 2'd0;
                                ack_pend_q <= 1'b0;
                            end else begin
                                // received pointer or data byte
                                if (phase_q == 2'd0) begin
                                    if (tg_q == TG_RTC) begin
                                        ptr_rtc_q <= {5'b00000, sh_q};
                                        phase_q <= 2'd2;
                                    end else if (LARGE_MEM) begin
                                        ptr_mem_q <= {sh_q[4:0], ptr_mem_q[7:0]};
                                        phase_q <= 2'd1;
                                    end else begin
                                        ptr_mem_q <= {ptr_mem_q[12:8], sh_q};
                                        phase_q <= 2'd2;
                                    end
                                end else if (phase_q == 2'd1) begin
                                    ptr_mem_q <= {ptr_mem_q[12:8], sh_q};
                                    phase_q <= 2'd2;
                                end else begin
                                    push_q <= fifo_ready;
                                    push_data_q <= {tg_q, cur_ptr, sh_q};
                                    if (tg_q == TG_RTC) ptr_rtc_q <= next_ptr;
                                    else ptr_mem_q <= next_ptr;
                                end
                                st_q <= ST_RACK;
                                sda_oe_out <= 1'b1;
                            end
                        end
                    end
                    ST_RACK: begin
                        // hold ack low through ninth clock
                        if (scl_fall) begin
                            sda_oe_out <= 1'b0;
                            if (rw_q && phase_q == 2'd0) begin
                                // read begins at held pointer
                                st_q <= ST_TX;
                                rd_req_out <= 1'b1;
                                rd_target_out <= tg_q;
                                rd_addr_out <= cur_ptr;
                                ack_pend_q <= 1'b1;
                            end else begin
                                st_q <= ST_RX;
                                sh_q <= 8'h00;
                            end
                            if (rw_q) phase_q <= 2'd2;
                        end
                    end
                    ST_TX: begin
                        // load fetched byte one cycle after request
                        if (ack_pend_q) begin
                            ack_pend_q <= 1'b0;
                            sh_q <= rd_data_in;
                            sda_out <= 1'b0;
                            sda_oe_out <= !rd_data_in[7];
                            bit_q <= 4'd0;
                        end else if (scl_fall) begin
                            if (bit_q == 4'd7) begin
                                sda_oe_out <= 1'b0; // let master answer
                                st_q <= ST_TACK;
                                if (tg_q == TG_RTC) ptr_rtc_q <= next_ptr;
                                else ptr_mem_q <= next_ptr;
                            end else begin
                                sda_oe_out <= !sh_q[6];
                                sh_q <= {sh_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'd1;
                            end
                        end
                    end
                    ST_TACK: begin
                        // master ack bit decides continue or release
                        if (scl_rise) begin
                            nack_q <= sda_s_q[1];
                        end else if (scl_fall) begin
                            if (nack_q) begin
                                st_q <= ST_IDLE;
                                sda_oe_out <= 1'b0;
                            end else begin
                                st_q <= ST_TX;
                                rd_req_out <= 1'b1;
                                rd_target_out <= tg_q;
                                rd_addr_out <= cur_ptr;
                                ack_pend_q <= 1'b1;
                            end
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // i2c_slave_access

// *** bench/i2c_access_sva.sv ***
// i2c_access_sva.sv: port assertions of the two-wire slave front end
// assumes a bus clock of eight system clocks, low for five of them
`timescale 1ns/1ps
`include "i2c_slave_defs.vh"

module i2c_access_sva #(
    parameter LARGE_MEM  = 0,
    parameter FIFO_DEPTH = 32
) (
    // clock, reset and pins
    input wire        clk_sys_in, rst_in, scl_in, sda_in, sda_out, sda_oe_out,
    // storage side and status
    input wire        wr_valid_out, wr_ready_in, rd_req_out, busy_out,
    input wire [1:0]  wr_target_out, rd_target_out,
    input wire [12:0] wr_addr_out, rd_addr_out,
    input wire [7:0]  wr_data_out, rd_data_in
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    // open drain: the level itself never goes high
    pin_low_only_a: assert property (sda_out == 1'b0)
        else $error("sda level driven high");
    // reset leaves drive, busy, write valid and read request quiet, so it is checked with no disable
    reset_quiet_a: assert property (disable iff (1'b0) rst_in |=>
        !sda_oe_out && !busy_out && !wr_valid_out && !rd_req_out) else $error("not quiet");
    // data may only move while the bus clock is low
    oe_scl_low_a: assert property ($changed(sda_oe_out) |-> !$past(scl_in, 2))
        else $error("sda changed with scl high");
    // start seen within the synchroniser delay
    start_busy_a: assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] busy_out)
        else $error("start not taken");
    stop_idle_a: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] !busy_out)
        else $error("stop not taken");
    // acknowledge only inside a transfer
    ack_in_xfer_a: assert property ($rose(sda_oe_out) |-> busy_out)
        else $error("drive outside transfer");
    rd_pulse_a: assert property (rd_req_out |-> busy_out ##1 !rd_req_out)
        else $error("read request not a pulse");
    // fetch addresses stay inside each space
    rtc_span_a: assert property (rd_req_out && rd_target_out == 2'h0 |->
        rd_addr_out <= `RTC_SPACE_LAST) else $error("clock address past end");
    mem_span_a: assert property (rd_req_out && LARGE_MEM == 0 && rd_target_out == 2'h1 |->
        rd_addr_out <= `MEM_SMALL_LAST) else $error("memory address past end");
    // a stalled word stands unchanged
    wr_hold_a: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out &&
        $stable({wr_target_out, wr_addr_out, wr_data_out})) else $error("word changed");
endmodule // i2c_access_sva

bind i2c_slave_access i2c_access_sva #(.LARGE_MEM(LARGE_MEM), .FIFO_DEPTH(FIFO_DEPTH)) sva_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .wr_valid_out(wr_valid_out),
    .wr_ready_in(wr_ready_in), .rd_req_out(rd_req_out), .busy_out(busy_out),
    .wr_target_out(wr_target_out), .rd_target_out(rd_target_out),
    .wr_addr_out(wr_addr_out), .rd_addr_out(rd_addr_out),
    .wr_data_out(wr_data_out), .rd_data_in(rd_data_in));

// *** bench/i2c_master_model.sv ***
// i2c_master_model.sv: behavioural bus master driving scl and sda
// assumes a pull-up on sda and 160 ns bus bits from a 20 ns clock
`timescale 1ns/1ps

module i2c_master_model (
    // timing reference and slave pull-down
    input  wire clk_sys_in,
    input  wire sda_oe_in,
    // bus lines
    output reg  scl_out,
    output wire sda_line_out
);
    reg sda_q;  // master side of the wired-and line

    // released line reads high through the pull-up
    assign sda_line_out = sda_q & ~sda_oe_in;
    initial begin
        sda_q = 1'b1;
        scl_out = 1'b1;
    end

    task automatic tick(input integer n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    // start: data falls with the clock high
    task automatic start;
        sda_q <= 1'b1;
        scl_out <= 1'b1;
        tick(3);
        sda_q <= 1'b0;
        tick(3);
        scl_out <= 1'b0;
    endtask
    // stop: data rises with the clock high
    task automatic stop;
        tick(2);
        sda_q <= 1'b0;
        tick(3);
        scl_out <= 1'b1;
        tick(3);
        sda_q <= 1'b1;
        tick(4);
    endtask
    // one bit: low five clocks, high three, sampled late in the high
    task automatic bit_io(input b, output r);
        tick(2);
        sda_q <= b;
        tick(3);
        scl_out <= 1'b1;
        tick(2);
        r = sda_line_out;
        tick(1);
        scl_out <= 1'b0;
    endtask
    // msb first, then the ninth clock for the slave's answer
    task automatic wbyte(input [7:0] b, output ack);
        reg r;
        integer i;
        for (i = 7; i >= 0; i = i - 1)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // read a byte; the last one is refused to end the read
    task automatic rbyte(input nack, output [7:0] d);
        reg r;
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule // i2c_master_model

// *** bench/tb.sv ***
// tb.sv: self-checking bench of the two-wire slave, both memory forms
// assumes the master model owns the bus and this module plays storage
`timescale 1ns/1ps
`include "i2c_slave_defs.vh"

module tb;
    localparam [34:0] BAD = {7'h69, 7'h48, 7'h2A, 7'h58, 7'h6C};  // foreign addresses
    reg         clk_sys_in, rst_in, wr_ready_in, stall_q;
    reg  [7:0]  seed, p;
    wire [7:0]  rd_data_in, rd_data_lg;  // storage lookups, combinational
    wire        busy, scl_lg, sda_lg, oe_lg;
    wire [1:0]  tg_lg;
    wire [12:0] ad_lg;
    reg  [22:0] exp_w;
    reg         a;
    wire        scl, sda, sda_oe_out, wr_valid_out, rd_req_out;
    wire [1:0]  wr_target_out, rd_target_out;
    wire [12:0] wr_addr_out, rd_addr_out;
    wire [7:0]  wr_data_out;
    integer     failures, n_checks, i, n;
    reg  [22:0] exp_q[$];  // expected write words in order

    i2c_slave_access #(.LARGE_MEM(0), .FIFO_DEPTH(`FIFO_DEPTH)) dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe_out(sda_oe_out), .wr_valid_out(wr_valid_out),
        .wr_ready_in(wr_ready_in), .wr_target_out(wr_target_out), .wr_addr_out(wr_addr_out),
        .wr_data_out(wr_data_out), .rd_req_out(rd_req_out), .rd_target_out(rd_target_out),
        .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in), .busy_out(busy));
    i2c_master_model m (.clk_sys_in(clk_sys_in), .sda_oe_in(sda_oe_out),
        .scl_out(scl), .sda_line_out(sda));
    // large memory form on a bus of its own, storage read only
    i2c_slave_access #(.LARGE_MEM(1), .FIFO_DEPTH(`FIFO_DEPTH)) dut_lg (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl_lg), .sda_in(sda_lg),
        .sda_out(), .sda_oe_out(oe_lg), .wr_valid_out(), .wr_ready_in(wr_ready_in),
        .wr_target_out(), .wr_addr_out(), .wr_data_out(), .rd_req_out(),
        .rd_target_out(tg_lg), .rd_addr_out(ad_lg), .rd_data_in(rd_data_lg), .busy_out());
    i2c_master_model m2 (.clk_sys_in(clk_sys_in), .sda_oe_in(oe_lg),
        .scl_out(scl_lg), .sda_line_out(sda_lg));

    function automatic [7:0] xs;
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 5);
        seed = seed ^ (seed << 3);
        xs = seed;
    endfunction
    // stored byte is a fixed function of target and address
    function automatic [7:0] pat(input [1:0] t, input [12:0] ad);
        pat = ad[7:0] ^ {3'h0, ad[12:8]} ^ {t, 6'h2A};
    endfunction
    // lookup must be valid the cycle after a fetch, so it is combinational
    assign rd_data_in = pat(rd_target_out, rd_addr_out);
    assign rd_data_lg = pat(tg_lg, ad_lg);
    task chk(input [22:0] got, input [22:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task test_done;
        if (failures == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // write: address, pointer, then n bytes; every byte is queued as a clock byte, up to the fifo depth
    task automatic wr_xfer(input [6:0] dev, input [7:0] ptr, input integer n);
        reg [7:0] d;
        reg [12:0] ad;
        integer k;
        ad = {5'h00, ptr};
        m.start;
        m.wbyte({dev, 1'b0}, a);
        chk(a, 1'b1);
        chk(busy, 1'b1);
        m.wbyte(ptr, a);
        chk(a, 1'b1);
        for (k = 0; k < n; k = k + 1) begin
            d = xs();
            if (exp_q.size() < `FIFO_DEPTH) exp_q.push_back({2'h0, ad, d});
            m.wbyte(d, a);
            if (k < `FIFO_DEPTH) chk(a, 1'b1);
            ad = (ad == `RTC_SPACE_LAST) ? `PTR_ZERO : ad + 13'h0001;
        end
        m.stop;
    endtask
    // read n bytes from ad onward, the last refused
    task automatic rd_xfer(input [6:0] dev, input [12:0] ad, input integer n);
        reg [7:0] d;
        reg [1:0] t;
        integer k;
        t = (dev == `RTC_ADDR) ? 2'h0 : 2'h1;
        m.start;
        m.wbyte({dev, `DIR_READ}, a);
        chk(a, 1'b1);
        for (k = 1; k <= n; k = k + 1) begin
            m.rbyte(k == n, d);
            chk(d, pat(t, ad));
            ad = (ad == (t ? `MEM_SMALL_LAST : `RTC_SPACE_LAST)) ? `PTR_ZERO : ad + 13'h0001;
        end
        repeat (5) @(posedge clk_sys_in);
        chk(sda_oe_out, 1'b0);
        m.stop;
        chk(busy, 1'b0);
    endtask
    // large form: foreign address, two pointer bytes, read across the top
    task automatic lg_run;
        reg [7:0] d;
        reg [12:0] ad;
        integer k;
        ad = 13'h1FFE;
        m2.start;
        m2.wbyte({7'h51, 1'b0}, a);
        chk(a, 1'b0);
        m2.stop;
        m2.start;
        m2.wbyte({`MEM_LARGE_ADDR, 1'b0}, a);
        chk(a, 1'b1);
        m2.wbyte({3'h0, ad[12:8]}, a);
        chk(a, 1'b1);
        m2.wbyte(ad[7:0], a);
        chk(a, 1'b1);
        m2.stop;
        m2.start;
        m2.wbyte({`MEM_LARGE_ADDR, `DIR_READ}, a);
        chk(a, 1'b1);
        for (k = 0; k < 3; k = k + 1) begin
            m2.rbyte(k == 2, d);
            chk(d, pat(2'h1, ad));
            ad = (ad == `MEM_LARGE_LAST) ? `PTR_ZERO : ad + 13'h0001;
        end
        m2.stop;
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // storage stand-in: write side takes words, stalls at random
    always @(posedge clk_sys_in) begin
        wr_ready_in <= ~stall_q & (xs() > 8'h64);
        if (wr_valid_out && wr_ready_in) begin
            exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 23'h7FFFFF;
            chk({wr_target_out, wr_addr_out, wr_data_out}, exp_w);
        end
    end
    // watchdog well past the expected run
    initial begin
        repeat (40000) @(posedge clk_sys_in);
        failures = failures + 1;
        test_done;
    end
    initial begin
        seed = 8'h4C;
        failures = 0;
        n_checks = 0;
        rst_in = 1'b1;
        stall_q = 1'b0;
        wr_ready_in = 1'b0;
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        rd_xfer(`RTC_ADDR, `PTR_ZERO, 1);
        wr_xfer(`RTC_ADDR, 8'h11, 3);
        rd_xfer(`RTC_ADDR, 13'h0001, 2);
        for (i = 0; i < 5; i = i + 1) begin
            m.start;
            m.wbyte({BAD[i*7 +: 7], xs() > 8'h7F}, a);
            chk(a, 1'b0);
            m.stop;
        end
        wr_xfer({`MEM_BLOCK_HI, 3'h7}, 8'hFF, 0);
        rd_xfer({`MEM_BLOCK_HI, 3'h7}, 13'h07FF, 2);
        rd_xfer({`MEM_BLOCK_HI, 3'h2}, 13'h0201, 1);
        lg_run;
        for (i = 0; i < 6; i = i + 1) begin
            p = xs() % 8'h13;
            n = 1 + xs() % 4;
            wr_xfer(`RTC_ADDR, p, n);
            wr_xfer(`RTC_ADDR, p, 0);
            rd_xfer(`RTC_ADDR, {5'h00, p}, n);
        end
        stall_q <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        wr_xfer(`RTC_ADDR, 8'h00, `FIFO_DEPTH + 2);
        chk(wr_valid_out, 1'b1);
        stall_q <= 1'b0;
        for (i = 0; i < 400 && exp_q.size() > 0; i = i + 1)
            @(posedge clk_sys_in);
        repeat (3) @(posedge clk_sys_in);
        chk(wr_valid_out, 1'b0);
        test_done;
    end
endmodule // tb
